// ### hw/lmbic_consts.svh
// register offsets, config bit positions, reset values and timing counts
`ifndef LMBIC_CONSTS_SVH
`define LMBIC_CONSTS_SVH

`define LMBIC_ADDR_GLOBAL_LEVEL 7'h02
`define LMBIC_ADDR_SCAN_LIMIT   7'h03
`define LMBIC_ADDR_CONFIG       7'h04
// upper address bits of the grouped ranges 0x10-0x17, 0x20-0x2F, 0x40-0x4F
`define LMBIC_ADDR_LEVEL_TOP    4'h2
`define LMBIC_ADDR_PLANE0_TOP   3'h2
`define LMBIC_ADDR_PLANE1_TOP   3'h4

`define LMBIC_CFG_RUN           0
`define LMBIC_CFG_RATE          2
`define LMBIC_CFG_BLINK_EN      3
`define LMBIC_CFG_BLINK_RST     4
`define LMBIC_CFG_CLEAR         5
`define LMBIC_CFG_PER_DIGIT     6
`define LMBIC_CFG_PHASE         7

`define LMBIC_RST_BYTE          8'h00
`define LMBIC_BLANK_CODE        8'h20
`define LMBIC_HEX_BLANK         7'h10

`define LMBIC_CLK_SYS_HZ        25000000
`define LMBIC_MUX_REF_HZ        4000000
`define LMBIC_DIGIT_TIME_US     200
`define LMBIC_FAST_BLINK_HZ     1
`define LMBIC_PWM_STEPS         16
`define LMBIC_DIGIT_TICKS       (`LMBIC_DIGIT_TIME_US * (`LMBIC_MUX_REF_HZ / 1000000))
`define LMBIC_FAST_PHASE_TICKS  (`LMBIC_MUX_REF_HZ / (2 * `LMBIC_FAST_BLINK_HZ))
`define LMBIC_OSC_HALF_CYCLES   (`LMBIC_CLK_SYS_HZ / (2 * `LMBIC_MUX_REF_HZ))

`endif

// ### hw/lmbic_font.sv
// character generator: 16-segment glyph and 7-segment hex glyph
`include "lmbic_consts.svh"
module lmbic_font (
  input  wire lmbic_pkg::lmbic_addr_t  code,
  output lmbic_pkg::lmbic_glyph_t      glyph16,
  output lmbic_pkg::lmbic_seg7_t       hex7
);
  import lmbic_pkg::*;

  function automatic lmbic_seg7_t hex_glyph(input logic [3:0] n);
    case (n)
      4'h0: return 7'h3F;
      4'h1: return 7'h06;
      4'h2: return 7'h5B;
      4'h3: return 7'h4F;
      4'h4: return 7'h66;
      4'h5: return 7'h6D;
      4'h6: return 7'h7D;
      4'h7: return 7'h07;
      4'h8: return 7'h7F;
      4'h9: return 7'h6F;
      4'hA: return 7'h77;
      4'hB: return 7'h7C;
      4'hC: return 7'h39;
      4'hD: return 7'h5E;
      4'hE: return 7'h79;
      default: return 7'h71;
    endcase
  endfunction : hex_glyph

  // 16-seg order {m,l,k,j,i,h,g2,g1,f,e,d2,d1,c,b,a2,a1}
  function automatic lmbic_glyph_t widen(input lmbic_seg7_t s);
    return {6'h00, s[6], s[6], s[5], s[4], s[3], s[3], s[2], s[1], s[0], s[0]};
  endfunction : widen

  always_comb begin
    hex7 = (code < `LMBIC_HEX_BLANK) ? hex_glyph(code[3:0]) : 7'h00;
    if (code < `LMBIC_HEX_BLANK) begin
      glyph16 = widen(hex_glyph(code[3:0]));
    end else if (code < 7'h28) begin
      glyph16 = 16'h0000;
    end else if (code == 7'(`LMBIC_BLANK_CODE)) begin
      glyph16 = 16'h0000;
    end else if (code >= 7'h30 && code <= 7'h39) begin
      glyph16 = widen(hex_glyph(4'(code - 7'h30)));
    end else if (code >= 7'h41 && code <= 7'h46) begin
      glyph16 = widen(hex_glyph(4'(code - 7'h37)));
    end else if (code >= 7'h61 && code <= 7'h66) begin
      glyph16 = widen(hex_glyph(4'(code - 7'h57)));
    end else if (code == 7'h2D) begin
      glyph16 = 16'h00C0;
    end else if (code == 7'h5F) begin
      glyph16 = 16'h000C;
    end else begin
      glyph16 = 16'h033F; // a1, a2, b, c, d1, d2, g1, g2 lit for glyphs not yet drawn
    end
  end
endmodule : lmbic_font

// ### hw/lmbic_led_mux_ctrl.sv
// multiplexed led display controller: blink planes, font, scan and brightness
// How it works
// - with blink enabled, display alternates between first and second data plane
// - code 0x20 renders blank, so pairing it with a glyph blinks it
// - blink alternation free-runs with no further register writes
// - blink speed comes from mux clock and one global rate bit
// - reset clears controls, blanks display, minimum intensity, shutdown
// - read/write config bit selects shutdown or normal operation
// - read/write config bit enables blinking for all digits
// - writing blink-reset bit restarts blink timing; bit never reads back set
// - writing clear bit blanks both planes for every digit; not stored
// - read-only config bit shows blink phase; writes to it ignored
// - low seven bits pick the glyph, top bit lights decimal point
// - ascii glyphs from 0x28 up; first sixteen entries are hex digits
// - each digit gets a slot derived from the mux clock, 200us at 4MHz
// - at 4MHz blink is 1Hz fast or 0.5Hz slow
// - clock copy output follows whichever mux clock is in use
// - internal oscillator stops while in shutdown
// - scan limit selects one to eight scanned digit positions
// - per-digit bit clear: all digits use global level low nibble
// - brightness in fifteen steps, 1/16 up to 15/16 of peak
// - at least 1/16 of each digit slot is always blanked
// - per-digit bit set: each digit uses its own nibble
// - with blink disabled, only the first plane is shown
`include "lmbic_consts.svh"
module lmbic_led_mux_ctrl #(
  parameter int DIGIT_TICKS      = `LMBIC_DIGIT_TICKS,
  parameter int FAST_PHASE_TICKS = `LMBIC_FAST_PHASE_TICKS,
  parameter int OSC_HALF_CYCLES  = `LMBIC_OSC_HALF_CYCLES,
  parameter bit FAST_WHEN_ONE    = 1'b1
) (
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  input  wire logic                    mux_clock_pin,
  input  wire logic                    ext_clock_select,
  input  wire lmbic_pkg::lmbic_addr_t  reg_addr,
  input  wire lmbic_pkg::lmbic_byte_t  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output lmbic_pkg::lmbic_byte_t       reg_rdata,
  output logic [7:0]                   digit_drive,
  output lmbic_pkg::lmbic_glyph_t      seg_main,
  output logic                         decimal_point_segment,
  output lmbic_pkg::lmbic_seg7_t       seg_extra,
  output logic                         decimal_point_extra,
  output logic                         mux_clock_copy_out
);
  import lmbic_pkg::*;

  localparam int SIXTEENTH = DIGIT_TICKS / `LMBIC_PWM_STEPS;

  // ---------------- clock source ----------------
  logic           pin_meta, pin_sync, pin_prev, sel_meta, sel_sync, osc_lvl;
  logic [3:0]     osc_cnt;
  logic           next_pin_meta, next_pin_sync, next_pin_prev;
  logic           next_sel_meta, next_sel_sync, next_osc_lvl, next_copy;
  logic [3:0]     next_osc_cnt;
  logic           mux_tick;
  lmbic_clk_src_e clk_src;
  logic           cfg_run;

  always_comb begin
    next_pin_meta = mux_clock_pin;
    next_pin_sync = pin_meta;
    next_pin_prev = pin_sync;
    next_sel_meta = ext_clock_select;
    next_sel_sync = sel_meta;
    clk_src       = sel_sync ? LMBIC_SRC_EXTERNAL : LMBIC_SRC_INTERNAL;
    next_osc_cnt  = osc_cnt;
    next_osc_lvl  = osc_lvl;
    if (!cfg_run || clk_src == LMBIC_SRC_EXTERNAL) begin
      next_osc_cnt = 4'h0;
      next_osc_lvl = 1'b0;
    end else if (osc_cnt == 4'(OSC_HALF_CYCLES - 1)) begin
      next_osc_cnt = 4'h0;
      next_osc_lvl = ~osc_lvl;
    end else begin
      next_osc_cnt = 4'(osc_cnt + 4'h1);
    end
    case (clk_src)
      LMBIC_SRC_EXTERNAL: begin
        next_copy = pin_sync;
        mux_tick  = cfg_run & pin_sync & ~pin_prev;
      end
      default: begin
        next_copy = osc_lvl;
        mux_tick  = cfg_run & ~osc_lvl & (osc_cnt == 4'(OSC_HALF_CYCLES - 1));
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_meta           <= 1'b0;
      pin_sync           <= 1'b0;
      pin_prev           <= 1'b0;
      sel_meta           <= 1'b0;
      sel_sync           <= 1'b0;
      osc_cnt            <= 4'h0;
      osc_lvl            <= 1'b0;
      mux_clock_copy_out <= 1'b0;
    end else if (ce) begin
      pin_meta           <= next_pin_meta;
      pin_sync           <= next_pin_sync;
      pin_prev           <= next_pin_prev;
      sel_meta           <= next_sel_meta;
      sel_sync           <= next_sel_sync;
      osc_cnt            <= next_osc_cnt;
      osc_lvl            <= next_osc_lvl;
      mux_clock_copy_out <= next_copy;
    end
  end

  // ---------------- register file ----------------
  lmbic_byte_t global_level, scan_limit;
  lmbic_byte_t level_reg [0:7];
  lmbic_byte_t plane [0:1][0:15];
  logic        cfg_rate, cfg_blink_en, cfg_per_digit, blink_phase;
  lmbic_byte_t next_global_level, next_scan_limit, next_rdata;
  lmbic_byte_t next_level_reg [0:7];
  lmbic_byte_t next_plane [0:1][0:15];
  logic        next_run, next_rate, next_blink_en, next_per_digit;
  logic        blink_restart;

  function automatic logic is_level(input lmbic_addr_t a);
    return a[6:3] == `LMBIC_ADDR_LEVEL_TOP;
  endfunction : is_level

  function automatic logic is_plane(input lmbic_addr_t a, input logic p);
    return a[6:4] == (p ? `LMBIC_ADDR_PLANE1_TOP : `LMBIC_ADDR_PLANE0_TOP);
  endfunction : is_plane

  always_comb begin
    next_global_level = global_level;
    next_scan_limit   = scan_limit;
    next_level_reg    = level_reg;
    next_plane        = plane;
    next_run          = cfg_run;
    next_rate         = cfg_rate;
    next_blink_en     = cfg_blink_en;
    next_per_digit    = cfg_per_digit;
    blink_restart     = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `LMBIC_ADDR_GLOBAL_LEVEL) begin
        next_global_level = reg_wdata;
      end else if (reg_addr == `LMBIC_ADDR_SCAN_LIMIT) begin
        next_scan_limit = reg_wdata;
      end else if (reg_addr == `LMBIC_ADDR_CONFIG) begin
        next_run       = reg_wdata[`LMBIC_CFG_RUN];
        next_rate      = reg_wdata[`LMBIC_CFG_RATE];
        next_blink_en  = reg_wdata[`LMBIC_CFG_BLINK_EN];
        next_per_digit = reg_wdata[`LMBIC_CFG_PER_DIGIT];
        blink_restart  = reg_wdata[`LMBIC_CFG_BLINK_RST];
        if (reg_wdata[`LMBIC_CFG_CLEAR]) begin
          for (int p = 0; p < 2; p++) begin
            for (int d = 0; d < 16; d++) begin
              next_plane[p][d] = `LMBIC_BLANK_CODE;
            end
          end
        end
      end else if (is_level(reg_addr)) begin
        next_level_reg[reg_addr[2:0]] = reg_wdata;
      end else if (is_plane(reg_addr, 1'b0)) begin
        next_plane[0][reg_addr[3:0]] = reg_wdata;
      end else if (is_plane(reg_addr, 1'b1)) begin
        next_plane[1][reg_addr[3:0]] = reg_wdata;
      end
    end
    next_rdata = reg_rdata;
    if (reg_rd) begin
      if (reg_addr == `LMBIC_ADDR_GLOBAL_LEVEL) begin
        next_rdata = global_level;
      end else if (reg_addr == `LMBIC_ADDR_SCAN_LIMIT) begin
        next_rdata = scan_limit;
      end else if (reg_addr == `LMBIC_ADDR_CONFIG) begin
        // transient bits read as zero, phase is live
        next_rdata = {blink_phase, cfg_per_digit, 2'b00, cfg_blink_en,
                      cfg_rate, 1'b0, cfg_run};
      end else if (is_level(reg_addr)) begin
        next_rdata = level_reg[reg_addr[2:0]];
      end else if (is_plane(reg_addr, 1'b0)) begin
        next_rdata = plane[0][reg_addr[3:0]];
      end else if (is_plane(reg_addr, 1'b1)) begin
        next_rdata = plane[1][reg_addr[3:0]];
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      global_level  <= `LMBIC_RST_BYTE;
      scan_limit    <= `LMBIC_RST_BYTE;
      cfg_run       <= 1'b0;
      cfg_rate      <= 1'b0;
      cfg_blink_en  <= 1'b0;
      cfg_per_digit <= 1'b0;
      reg_rdata     <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        level_reg[i] <= `LMBIC_RST_BYTE;
      end
      for (int p = 0; p < 2; p++) begin
        for (int d = 0; d < 16; d++) begin
          plane[p][d] <= `LMBIC_BLANK_CODE;
        end
      end
    end else if (ce) begin
      global_level  <= next_global_level;
      scan_limit    <= next_scan_limit;
      cfg_run       <= next_run;
      cfg_rate      <= next_rate;
      cfg_blink_en  <= next_blink_en;
      cfg_per_digit <= next_per_digit;
      reg_rdata     <= next_rdata;
      level_reg     <= next_level_reg;
      plane         <= next_plane;
    end
  end

  // ---------------- scan and blink timing ----------------
  logic [15:0] sub_cnt, next_sub_cnt;
  logic [3:0]  sixteenth, next_sixteenth;
  logic [2:0]  slot, next_slot;
  logic [23:0] blink_cnt, next_blink_cnt, phase_last;
  logic        next_blink_phase;

  always_comb begin
    next_sub_cnt     = sub_cnt;
    next_sixteenth   = sixteenth;
    next_slot        = slot;
    next_blink_cnt   = blink_cnt;
    next_blink_phase = blink_phase;
    phase_last = (cfg_rate == FAST_WHEN_ONE) ? 24'(FAST_PHASE_TICKS - 1)
                                             : 24'(2 * FAST_PHASE_TICKS - 1);
    if (mux_tick) begin
      if (sub_cnt == 16'(SIXTEENTH - 1)) begin
        next_sub_cnt   = 16'h0000;
        next_sixteenth = 4'(sixteenth + 4'h1);
        if (sixteenth == 4'hF) begin
          next_slot = (slot >= scan_limit[2:0]) ? 3'h0 : 3'(slot + 3'h1);
        end
      end else begin
        next_sub_cnt = 16'(sub_cnt + 16'h0001);
      end
    end
    if (blink_restart) begin
      next_blink_cnt   = 24'h000000;
      next_blink_phase = 1'b0;
    end else if (mux_tick) begin
      if (blink_cnt >= phase_last) begin
        next_blink_cnt   = 24'h000000;
        next_blink_phase = ~blink_phase;
      end else begin
        next_blink_cnt = 24'(blink_cnt + 24'h000001);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sub_cnt     <= 16'h0000;
      sixteenth   <= 4'h0;
      slot        <= 3'h0;
      blink_cnt   <= 24'h000000;
      blink_phase <= 1'b0;
    end else if (ce) begin
      sub_cnt     <= next_sub_cnt;
      sixteenth   <= next_sixteenth;
      slot        <= next_slot;
      blink_cnt   <= next_blink_cnt;
      blink_phase <= next_blink_phase;
    end
  end

  // ---------------- font, brightness and drive ----------------
  logic         shown_plane, on_main, on_extra;
  lmbic_byte_t  code_main, code_extra, lvl_pair_main, lvl_pair_extra;
  lmbic_level_t lvl_main, lvl_extra;
  lmbic_glyph_t glyph_main;
  lmbic_seg7_t  hex_extra;
  logic [7:0]   next_drive;
  lmbic_glyph_t next_seg_main;
  lmbic_seg7_t  next_seg_extra;
  logic         next_dp_main, next_dp_extra;

  // on for level+1 sixteenths, last sixteenth always dark
  function automatic logic pwm_on(input lmbic_level_t lvl, input logic [3:0] s);
    return (s <= lvl) && (s != 4'hF);
  endfunction : pwm_on

  function automatic lmbic_level_t pick_nibble(input lmbic_byte_t b, input logic odd);
    return odd ? b[7:4] : b[3:0];
  endfunction : pick_nibble

  lmbic_font u_font_main (
    .code    (code_main[6:0]),
    .glyph16 (glyph_main),
    .hex7    ()
  );

  lmbic_font u_font_extra (
    .code    (code_extra[6:0]),
    .glyph16 (),
    .hex7    (hex_extra)
  );

  always_comb begin
    shown_plane    = cfg_blink_en & blink_phase;
    code_main      = plane[shown_plane][{1'b0, slot}];
    code_extra     = plane[shown_plane][{1'b1, slot}];
    lvl_pair_main  = level_reg[{1'b0, slot[2:1]}];
    lvl_pair_extra = level_reg[{1'b1, slot[2:1]}];
    if (cfg_per_digit) begin
      lvl_main  = pick_nibble(lvl_pair_main, slot[0]);
      lvl_extra = pick_nibble(lvl_pair_extra, slot[0]);
    end else begin
      lvl_main  = global_level[3:0];
      lvl_extra = global_level[3:0];
    end
    on_main        = cfg_run & pwm_on(lvl_main, sixteenth);
    on_extra       = cfg_run & pwm_on(lvl_extra, sixteenth);
    next_drive     = (on_main | on_extra) ? (8'h01 << slot) : 8'h00;
    next_seg_main  = on_main ? glyph_main : 16'h0000;
    next_dp_main   = on_main & code_main[7];
    next_seg_extra = on_extra ? hex_extra : 7'h00;
    next_dp_extra  = on_extra & code_extra[7];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      digit_drive           <= 8'h00;
      seg_main              <= 16'h0000;
      decimal_point_segment <= 1'b0;
      seg_extra             <= 7'h00;
      decimal_point_extra   <= 1'b0;
    end else if (ce) begin
      digit_drive           <= next_drive;
      seg_main              <= next_seg_main;
      decimal_point_segment <= next_dp_main;
      seg_extra             <= next_seg_extra;
      decimal_point_extra   <= next_dp_extra;
    end
  end
endmodule : lmbic_led_mux_ctrl

// ### hw/lmbic_pkg.sv
// shared types of the led multiplex controller
package lmbic_pkg;
  typedef logic [7:0]  lmbic_byte_t;
  typedef logic [6:0]  lmbic_addr_t;
  typedef logic [3:0]  lmbic_level_t;
  typedef logic [15:0] lmbic_glyph_t;
  typedef logic [6:0]  lmbic_seg7_t;
  typedef enum logic {
    LMBIC_SRC_INTERNAL,
    LMBIC_SRC_EXTERNAL
  } lmbic_clk_src_e;
endpackage : lmbic_pkg

// ### verif/lmbic_display_model.sv
// display model: records what the last lit digit showed and how long each cathode digit stays on
module lmbic_display_model (
  input wire logic                    clk_sys,
  input wire logic [7:0]              digit_drive,
  input wire lmbic_pkg::lmbic_glyph_t seg_main,
  input wire logic                    decimal_point_segment,
  input wire lmbic_pkg::lmbic_seg7_t  seg_extra,
  input wire logic                    decimal_point_extra
);
  timeunit 1ns;
  timeprecision 1ps;
  import lmbic_pkg::*;
  logic [7:0]   seen = 8'h00;
  logic [7:0]   acc = 8'h00;
  logic [7:0]   last_extra = 8'h00;
  logic         prev0 = 1'b0;
  logic         last_dp = 1'b0;
  lmbic_glyph_t last_glyph = 16'h0000;
  int           run_len[8];
  int           on_len[8];
  int           gap_cnt = 0;
  int           d0_gap = 0;

  always @(posedge clk_sys) begin
    for (int i = 0; i < 8; i++) begin
      run_len[i] <= digit_drive[i] ? run_len[i] + 1 : 0;
      if (!digit_drive[i] && run_len[i] != 0) on_len[i] <= run_len[i];
    end
    acc <= (digit_drive[0] && !prev0) ? digit_drive : acc | digit_drive;
    gap_cnt <= (digit_drive[0] && !prev0) ? 1 : gap_cnt + 1;
    if (digit_drive[0] && !prev0) begin
      d0_gap <= gap_cnt;
      seen <= acc;
    end
    prev0 <= digit_drive[0];
    if (digit_drive != 8'h00) begin
      last_glyph <= seg_main;
      last_dp <= decimal_point_segment;
      last_extra <= {decimal_point_extra, seg_extra};
    end
  end
endmodule : lmbic_display_model

// ### verif/lmbic_led_mux_ctrl_tb.sv
// self-checking bench of the led multiplex controller
module lmbic_led_mux_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lmbic_pkg::*;
  localparam int DT   = 32;
  localparam int SIX  = DT / 16 * 6;
  localparam int SLOT = DT * 6;
  logic         clk_sys = 1'b0;
  logic         resetn = 1'b0;
  logic         ce = 1'b1;
  logic         mux_clock_pin = 1'b0;
  logic         ext_clock_select = 1'b0;
  logic         pin_run = 1'b0;
  lmbic_addr_t  reg_addr = 7'h00;
  lmbic_byte_t  reg_wdata = 8'h00;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  lmbic_byte_t  reg_rdata;
  logic [7:0]   digit_drive;
  lmbic_glyph_t seg_main;
  logic         decimal_point_segment;
  lmbic_seg7_t  seg_extra;
  logic         decimal_point_extra;
  logic         mux_clock_copy_out;
  int           miscompares = 0;
  int           tests_run = 0;
  int           pin_cnt = 0;
  int           n, m;
  lmbic_byte_t  rv;
  lmbic_glyph_t ga, gb;
  lmbic_addr_t  ra[5] = '{7'h04, 7'h02, 7'h20, 7'h4F, 7'h7F};
  lmbic_byte_t  rx[5] = '{8'h00, 8'h00, 8'h20, 8'h20, 8'h00};
  lmbic_byte_t  lv[4] = '{8'h00, 8'h05, 8'h0E, 8'h0F};
  lmbic_byte_t  sl[2] = '{8'h02, 8'h07};

  lmbic_led_mux_ctrl #(.DIGIT_TICKS(DT), .FAST_PHASE_TICKS(20), .OSC_HALF_CYCLES(3))
  i_lmbic_led_mux_ctrl (
    .clk_sys, .resetn, .ce, .mux_clock_pin, .ext_clock_select,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .digit_drive, .seg_main, .decimal_point_segment,
    .seg_extra, .decimal_point_extra, .mux_clock_copy_out
  );

  lmbic_display_model i_lmbic_display_model (
    .clk_sys, .digit_drive, .seg_main, .decimal_point_segment,
    .seg_extra, .decimal_point_extra
  );

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // external mux clock, toggles every five system cycles while enabled
  always @(posedge clk_sys) begin
    if (pin_run) begin
      pin_cnt <= (pin_cnt == 4) ? 0 : pin_cnt + 1;
      if (pin_cnt == 4) mux_clock_pin <= ~mux_clock_pin;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic wr(input lmbic_addr_t a, input lmbic_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input lmbic_addr_t a, output lmbic_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  task automatic count_rises(input int cyc, output int k);
    logic p;
    k = 0;
    p = mux_clock_copy_out;
    repeat (cyc) begin
      @(negedge clk_sys);
      if (mux_clock_copy_out && !p) k++;
      p = mux_clock_copy_out;
    end
  endtask : count_rises

  // polls the phase bit every cycle; times the first and second change
  task automatic blink_half(output int first, output int half,
                            output lmbic_glyph_t g1, output lmbic_glyph_t g2);
    logic p;
    int   k;
    int   ch;
    @(posedge clk_sys);
    reg_addr <= 7'h04;
    reg_rd <= 1'b1;
    repeat (2) @(negedge clk_sys);
    p = reg_rdata[7];
    k = 0;
    ch = 0;
    first = 0;
    half = 0;
    g1 = 16'h0000;
    g2 = 16'h0000;
    while (!(ch == 2 && k == 30)) begin
      @(negedge clk_sys);
      k++;
      if (reg_rdata[7] !== p) begin
        p = reg_rdata[7];
        ch++;
        if (ch == 1) first = k;
        if (ch == 2) half = k;
        k = 0;
      end
      if (k == 30 && ch == 1) g1 = i_lmbic_display_model.last_glyph;
      if (k == 30 && ch == 2) g2 = i_lmbic_display_model.last_glyph;
      if (k > 1000) begin
        miscompares++;
        print_verdict();
      end
    end
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : blink_half

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    chk(digit_drive, 8'h00, "dark after reset");
    wr(7'h7F, 8'hFF);
    foreach (ra[i]) begin
      rd(ra[i], rv);
      chk(rv, rx[i], "reset value");
    end
    wr(7'h20, 8'h88);
    wr(7'h28, 8'h85);
    wr(7'h40, 8'h20);
    wr(7'h04, 8'h01);
    foreach (lv[i]) begin
      wr(7'h02, lv[i]);
      repeat (3 * SLOT) @(posedge clk_sys);
      chk(i_lmbic_display_model.on_len[0], (lv[i] > 8'h0D ? 15 : lv[i] + 1) * SIX, "on time");
    end
    chk(i_lmbic_display_model.last_dp, 1'b1, "decimal point");
    chk(i_lmbic_display_model.last_extra, 8'hED, "extra digit");
    chk(i_lmbic_display_model.last_glyph != 16'h0000, 1'b1, "first plane");
    count_rises(120, n);
    chk(n > 18 && n < 22, 1'b1, "internal clock copy");
    foreach (sl[i]) begin
      wr(7'h03, sl[i]);
      repeat ((2 * sl[i] + 3) * SLOT) @(posedge clk_sys);
      chk(i_lmbic_display_model.seen, 8'hFF >> (7 - sl[i]), "scanned digits");
      chk(i_lmbic_display_model.d0_gap, (sl[i] + 1) * SLOT, "scan period");
    end
    wr(7'h03, 8'h01);
    wr(7'h10, 8'h30);
    wr(7'h02, 8'h0F);
    wr(7'h04, 8'h41);
    repeat (8 * SLOT) @(posedge clk_sys);
    chk(i_lmbic_display_model.on_len[0], SIX, "digit 0 level");
    chk(i_lmbic_display_model.on_len[1], 4 * SIX, "digit 1 level");
    wr(7'h03, 8'h00);
    wr(7'h04, 8'h1D);
    blink_half(n, m, ga, gb);
    chk(m, 120, "fast blink half");
    chk((ga == 16'h0000) ^ (gb == 16'h0000), 1'b1, "planes alternate");
    wr(7'h04, 8'h1D);
    rd(7'h04, rv);
    chk(rv[6:0], 7'h0D, "transient bits");
    blink_half(n, m, ga, gb);
    chk(n > 104 && n < 126, 1'b1, "blink restart");
    wr(7'h04, 8'h09);
    blink_half(n, m, ga, gb);
    chk(m, 240, "slow blink half");
    wr(7'h47, 8'h05);
    wr(7'h04, 8'h21);
    rd(7'h47, rv);
    chk(rv, 8'h20, "plane cleared");
    repeat (2 * SLOT) @(posedge clk_sys);
    chk(i_lmbic_display_model.last_glyph, 16'h0000, "blank glyph");
    chk(i_lmbic_display_model.last_dp, 1'b0, "dp cleared");
    wr(7'h02, 8'h00);
    @(posedge clk_sys);
    ext_clock_select <= 1'b1;
    pin_run <= 1'b1;
    count_rises(400, n);
    chk(n > 38 && n < 42, 1'b1, "external clock copy");
    @(posedge clk_sys);
    ext_clock_select <= 1'b0;
    pin_run <= 1'b0;
    wr(7'h04, 8'h00);
    repeat (20) @(posedge clk_sys);
    count_rises(100, n);
    chk(n, 0, "oscillator stopped");
    chk(digit_drive, 8'h00, "dark in shutdown");
    print_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end
endmodule : lmbic_led_mux_ctrl_tb

// ### verif/lmbic_mux_monitor.sv
// assertion checker bound to the led multiplex controller
module lmbic_mux_monitor #(
  parameter int DIGIT_TICKS     = 800,
  parameter int OSC_HALF_CYCLES = 3
) (
  input wire logic                   clk_sys,
  input wire logic                   resetn,
  input wire logic                   ce,
  input wire logic                   mux_clock_pin,
  input wire logic                   ext_clock_select,
  input wire lmbic_pkg::lmbic_addr_t reg_addr,
  input wire lmbic_pkg::lmbic_byte_t reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire lmbic_pkg::lmbic_byte_t reg_rdata,
  input wire logic [7:0]             digit_drive,
  input wire logic                   mux_clock_copy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import lmbic_pkg::*;
  localparam int SIX = DIGIT_TICKS / 16 * 2 * OSC_HALF_CYCLES;
  lmbic_byte_t cfg_q, next_cfg_q, quiet, next_quiet;
  logic [3:0]  glob_q, next_glob_q;
  logic [2:0]  ext_cnt, next_ext_cnt;
  int          on_cnt, next_on_cnt;

  // mirror of stored config and level, time since last write, lit run length
  always_comb begin
    next_cfg_q = (ce && reg_wr && reg_addr == 7'h04) ? (reg_wdata & 8'h4D) : cfg_q;
    next_glob_q = (ce && reg_wr && reg_addr == 7'h02) ? reg_wdata[3:0] : glob_q;
    next_quiet = (reg_wr || ext_clock_select) ? 8'h00 :
                 (quiet == 8'hFF) ? quiet : quiet + 8'h01;
    next_ext_cnt = !ext_clock_select ? 3'h0 : (ext_cnt == 3'h7) ? ext_cnt : ext_cnt + 3'h1;
    next_on_cnt = (digit_drive == 8'h00) ? 0 : on_cnt + 1;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_q   <= 8'h00;
      glob_q  <= 4'h0;
      quiet   <= 8'h00;
      ext_cnt <= 3'h0;
      on_cnt  <= 0;
    end else begin
      cfg_q   <= next_cfg_q;
      glob_q  <= next_glob_q;
      quiet   <= next_quiet;
      ext_cnt <= next_ext_cnt;
      on_cnt  <= next_on_cnt;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  drive_onehot_a: assert property ($onehot0(digit_drive))
    else $error("more than one digit driven");
  shutdown_dark_a: assert property (
    !cfg_q[0] && !$past(cfg_q[0]) |-> digit_drive == 8'h00)
    else $error("digit driven in shutdown");
  osc_stopped_a: assert property (
    !cfg_q[0] && quiet > 8'h08 |-> $stable(mux_clock_copy_out))
    else $error("clock copy moves in shutdown");
  cfg_read_a: assert property (
    ce && reg_rd && reg_addr == 7'h04 |=> reg_rdata[6:0] == $past(cfg_q[6:0]))
    else $error("config readback wrong");
  level_read_a: assert property (
    ce && reg_rd && reg_addr == 7'h02 |=> reg_rdata[3:0] == $past(glob_q))
    else $error("global level readback wrong");
  on_time_a: assert property (
    cfg_q[0] && !cfg_q[6] && quiet == 8'hFF && digit_drive == 8'h00 && on_cnt != 0
    |-> on_cnt == (glob_q > 4'hD ? 15 : int'(glob_q) + 1) * SIX)
    else $error("digit on time does not match level");
  dark_gap_a: assert property (
    quiet == 8'hFF |-> on_cnt <= 15 * SIX)
    else $error("no dark sixteenth in a slot");
  ext_copy_a: assert property (
    cfg_q[0] && ext_cnt == 3'h7 && $rose(mux_clock_pin) |-> ##[1:5] $rose(mux_clock_copy_out))
    else $error("clock copy does not follow pin");
endmodule : lmbic_mux_monitor

bind lmbic_led_mux_ctrl lmbic_mux_monitor #(
  .DIGIT_TICKS(DIGIT_TICKS),
  .OSC_HALF_CYCLES(OSC_HALF_CYCLES)
) i_lmbic_mux_monitor (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .ce(ce),
  .mux_clock_pin(mux_clock_pin),
  .ext_clock_select(ext_clock_select),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .digit_drive(digit_drive),
  .mux_clock_copy_out(mux_clock_copy_out)
);
